// ===== logic/sqno_consts.svh
`ifndef SQNO_CONSTS_SVH
`define SQNO_CONSTS_SVH
// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define SQNO_ADDR_QUERY        4'h0
`define SQNO_ADDR_SYS_STATUS   4'h1
`define SQNO_ADDR_SYS_CONTROL  4'h2
`define SQNO_ADDR_FRAME_SIZE   4'h3
`define SQNO_ADDR_BASIC_CTRL   4'h4
`define SQNO_ADDR_RECV_FLAGS   4'h5
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SQNO_QRY_TARGET_LSB    0
`define SQNO_QRY_REQ_BIT       6
`define SQNO_QRY_PULSE_BIT     7
`define SQNO_QRY_TYPE_LSB      8
`define SQNO_SSR_GUARD_MASK    16'h0700
`define SQNO_SCR_TIME_LSB      0
`define SQNO_SCR_START_BIT     7
`define SQNO_SCR_MONITOR_BIT   8
`define SQNO_SCR_LONG_BIT      14
`define SQNO_BCR_SELECT_BIT    15
// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define SQNO_FRAME_SIZE_INIT   6'h3f
`define SQNO_LONG_FRAME_LEN    9'h100
`define SQNO_NORMAL_FRAME_LEN  9'h080
`define SQNO_TYPE_MEM_NOFRM    5'h00
`define SQNO_TYPE_MEM_FRM      5'h01
`define SQNO_TYPE_IO_NOFRM     5'h02
`define SQNO_TYPE_IO_FRM       5'h03
`define SQNO_TYPE_MEM_OWNEXP   5'h04
`endif

// ===== logic/sqno_pkg.sv
`default_nettype none
package sqno_pkg;
  typedef enum logic [1:0] {
    SQNO_IDLE  = 2'b00,
    SQNO_QWAIT = 2'b01,
    SQNO_PSEND = 2'b10
  } sqno_state_t;

  typedef struct packed {
    sqno_state_t state;
    logic [5:0]  target;
    logic        qreq;
    logic        preq;
    logic [4:0]  stype;
    logic [3:0]  gpo;
    logic [6:0]  stime;
    logic        start;
    logic        monitor;
    logic        long_frame;
    logic        lfs;
    logic [5:0]  fsize;
    logic [63:0] rflags;
    logic [63:0] rcur;
    logic [15:0] rdata;
  } sqno_dev_state_t;

  typedef struct packed {
    logic       valid;
    logic [5:0] target;
    logic [4:0] stype;
    logic       busy;
    logic       ans_q;
    logic [6:0] cnt;
  } sqno_far_state_t;
endpackage
`default_nettype wire

// ===== logic/sqno_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sqno_link_if;
  logic       query_valid;
  logic [5:0] query_target;
  logic       query_answer;
  logic [4:0] answer_type;
  logic       pulse_valid;
  logic [5:0] pulse_target;
  logic       pulse_ack;
  logic       long_frame_net;
  logic       cycle_wrap;
  logic [5:0] rx_station;
  logic       rx_valid;

  modport dev (output query_valid, query_target, pulse_valid, pulse_target,
               input query_answer, answer_type, pulse_ack, long_frame_net,
               cycle_wrap, rx_station, rx_valid);
  modport far (input query_valid, query_target, pulse_valid, pulse_target,
               output query_answer, answer_type, pulse_ack, long_frame_net,
               cycle_wrap, rx_station, rx_valid);
endinterface // sqno_link_if
`default_nettype wire

// ===== logic/sqno_device.sv
// Function
// R1: host writes target and query request
// R2: on answer clear request, store type
// R3: no answer keeps request set forever
// R4: host abandons query by writing zero
// R5: pulse command refused while query pending
// R6: type codes zero to three modes
// R7: code four owned expansion, rest reserved
// R8: status bits zero-three drive output pins
// R9: guard bits eight-ten block pin write
// R10: reset drives output pins low
// R11: monitor entered only while start zero
// R12: monitor ignores own address and width
// R13: monitor flags update at station time zero
// R14: monitor flag means station active refreshed
// R15: frame size holds initial value
// R16: long frame uses length 256
// R17: host selects long frame before start
// R18: long frame adopted from network
// R19: long frame status set when applied
// R20: long frame status cleared only by reset
// R21: no long frame with simultaneous resize
// R22: pulse command bit cleared when sent
// R23: device-only fields ignore host writes
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "sqno_consts.svh"
module sqno_device (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [3:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [15:0]     rdata,
  output logic [3:0]      general_output_pins,
  output logic [8:0]      frame_length,
  input  wire logic [5:0] station_address,
  input  wire logic [5:0] owned_width,
  sqno_link_if.dev        link
);
  import sqno_pkg::*;

  sqno_dev_state_t s_q;
  sqno_dev_state_t s_d;
  logic            own_hit;
  logic            pulse_wr;

  // ----------------------------------------------------------------
  // combinational next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    pulse_wr = wr && (addr == `SQNO_ADDR_QUERY) && wdata[`SQNO_QRY_PULSE_BIT];
    // ----------------------------------------------------------------
    // own station hits, linking only
    // ----------------------------------------------------------------
    own_hit = !s_q.monitor && link.rx_valid && (link.rx_station == station_address)
              && (owned_width != 6'h00); // R12
    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (wr) begin
      case (addr)
        `SQNO_ADDR_QUERY: begin
          s_d.target = wdata[`SQNO_QRY_TARGET_LSB +: 6]; // R1
          s_d.qreq   = wdata[`SQNO_QRY_REQ_BIT]; // R4
          if (!wdata[`SQNO_QRY_REQ_BIT]) begin
            s_d.state = SQNO_IDLE;
          end
          if (wdata[`SQNO_QRY_PULSE_BIT]) begin
            s_d.preq = 1'b1;
          end
        end
        `SQNO_ADDR_SYS_STATUS: begin
          if ((wdata & `SQNO_SSR_GUARD_MASK) == 16'h0000) begin // R9
            s_d.gpo = wdata[3:0]; // R8
          end
        end
        `SQNO_ADDR_SYS_CONTROL: begin
          s_d.start = wdata[`SQNO_SCR_START_BIT];
          if (!s_q.start || !wdata[`SQNO_SCR_MONITOR_BIT]) begin
            s_d.monitor = wdata[`SQNO_SCR_MONITOR_BIT]; // R11
          end
        end
        `SQNO_ADDR_BASIC_CTRL: begin
          if (!s_q.start) begin
            s_d.lfs = wdata[`SQNO_BCR_SELECT_BIT]; // R17
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // station time, wraps each cycle
    // ----------------------------------------------------------------
    if (link.cycle_wrap) begin
      s_d.stime = 7'h00;
    end else begin
      s_d.stime = s_q.stime + 7'h01;
    end

    // ----------------------------------------------------------------
    // monitor receive flags
    // ----------------------------------------------------------------
    if (!s_q.monitor) begin
      s_d.rcur = 64'h0;
    end
    if (s_q.monitor && link.rx_valid) begin
      s_d.rcur[link.rx_station] = 1'b1; // R14
    end
    if (s_q.monitor && s_q.stime == 7'h00) begin
      s_d.rflags = s_q.rcur; // R13
      s_d.rcur   = 64'h0;
      if (link.rx_valid) begin
        s_d.rcur[link.rx_station] = 1'b1;
      end
    end
    if (own_hit) begin
      s_d.rflags[link.rx_station] = 1'b1;
    end

    // ----------------------------------------------------------------
    // long frame from host select or network, sticky
    // ----------------------------------------------------------------
    if ((s_q.lfs && s_q.start) || link.long_frame_net) begin
      s_d.long_frame = 1'b1; // R18 R19 R20
    end
    s_d.fsize = s_q.fsize; // R15

    // ----------------------------------------------------------------
    // query and pulse engine
    // ----------------------------------------------------------------
    case (s_q.state)
      SQNO_IDLE: begin
        if (s_q.qreq) begin
          s_d.state = SQNO_QWAIT;
        end else if (s_q.preq) begin // R5
          s_d.state = SQNO_PSEND;
        end
      end
      SQNO_QWAIT: begin
        if (!s_q.qreq) begin
          s_d.state = SQNO_IDLE;
        end else if (link.query_answer) begin
          s_d.qreq  = 1'b0; // R2
          s_d.stype = link.answer_type; // R6 R7
          s_d.state = SQNO_IDLE;
        end
        // no answer: stay here, no timeout R3
      end
      SQNO_PSEND: begin
        if (link.pulse_ack) begin
          if (!pulse_wr) begin
            s_d.preq = 1'b0; // R22
          end
          s_d.state = SQNO_IDLE;
        end
      end
      default: begin
        s_d.state = SQNO_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // read mux, answer one cycle later
    // ----------------------------------------------------------------
    s_d.rdata = 16'h0000;
    if (rd) begin
      case (addr)
        `SQNO_ADDR_QUERY:
          s_d.rdata = {3'h0, s_q.stype, s_q.preq, s_q.qreq, s_q.target}; // R23
        `SQNO_ADDR_SYS_STATUS:  s_d.rdata = {12'h000, s_q.gpo};
        `SQNO_ADDR_SYS_CONTROL:
          s_d.rdata = {1'b0, s_q.long_frame, 5'h00, s_q.monitor, s_q.start, s_q.stime};
        `SQNO_ADDR_FRAME_SIZE:  s_d.rdata = {10'h000, s_q.fsize};
        `SQNO_ADDR_BASIC_CTRL:  s_d.rdata = {s_q.lfs, 15'h0000};
        `SQNO_ADDR_RECV_FLAGS:  s_d.rdata = s_q.rflags[15:0];
        default:                s_d.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q            <= '0;
      s_q.state      <= SQNO_IDLE;
      s_q.gpo        <= 4'h0; // R10
      s_q.long_frame <= 1'b0; // R20
      s_q.fsize      <= `SQNO_FRAME_SIZE_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata               = s_q.rdata;
  assign general_output_pins = s_q.gpo;
  assign frame_length        = s_q.long_frame ? `SQNO_LONG_FRAME_LEN
                                              : `SQNO_NORMAL_FRAME_LEN; // R16
  assign link.query_valid    = (s_q.state == SQNO_QWAIT);
  assign link.query_target   = s_q.target;
  assign link.pulse_valid    = (s_q.state == SQNO_PSEND);
  assign link.pulse_target   = s_q.target;
endmodule // sqno_device
`default_nettype wire

// ===== logic/sqno_far_station.sv
`timescale 1ns/100ps
`default_nettype none
`include "sqno_consts.svh"
module sqno_far_station #(
  parameter logic [6:0] CYCLE_LEN = 7'h7f
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [63:0] present,
  input  wire logic [4:0] type_code,
  input  wire logic       net_long_frame,
  input  wire logic       rx_valid_in,
  input  wire logic [5:0] rx_station_in,
  output logic            pulse_seen,
  sqno_link_if.far        link
);
  import sqno_pkg::*;

  sqno_far_state_t f_q;
  sqno_far_state_t f_d;

  // ----------------------------------------------------------------
  // answer a query from present stations only
  // ----------------------------------------------------------------
  always_comb begin
    f_d       = f_q;
    f_d.ans_q = 1'b0;
    if (link.query_valid && !f_q.ans_q && present[link.query_target]) begin // R3
      f_d.ans_q = 1'b1;
      f_d.stype = type_code; // R6 R7
    end
    f_d.busy   = link.pulse_valid && !f_q.busy;
    f_d.valid  = rx_valid_in;
    f_d.target = rx_station_in;
    f_d.cnt    = (f_q.cnt == CYCLE_LEN) ? 7'h00 : f_q.cnt + 7'h01;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  assign link.query_answer   = f_q.ans_q;
  assign link.answer_type    = f_q.stype;
  assign link.pulse_ack      = f_q.busy;
  assign link.long_frame_net = net_long_frame; // R18
  assign link.cycle_wrap     = (f_q.cnt == CYCLE_LEN);
  assign link.rx_valid       = f_q.valid;
  assign link.rx_station     = f_q.target;
  assign pulse_seen          = f_q.busy;
endmodule // sqno_far_station
`default_nettype wire

// ===== verification/sqno_props.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// link checks
// ----------------------------------------------------------------
module sqno_props (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       query_valid,
  input wire logic [5:0] query_target,
  input wire logic       query_answer,
  input wire logic [4:0] answer_type,
  input wire logic       pulse_valid,
  input wire logic [5:0] pulse_target,
  input wire logic       pulse_ack
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_pulse_refused: assert property (query_valid |-> !pulse_valid)
    else $error("pulse issued while query pending");
  a_query_clears: assert property (query_answer |-> ##[1:3] !query_valid)
    else $error("query still pending after answer");
  a_answer_cause: assert property (query_answer |-> $past(query_valid))
    else $error("answer without query");
  a_answer_code: assert property (query_answer |-> answer_type <= 5'h04)
    else $error("reserved type code answered");
  a_target_held: assert property (query_valid && $past(query_valid)
    |-> $stable(query_target))
    else $error("query target moved");
  a_pulse_held: assert property (pulse_valid && !pulse_ack
    |=> pulse_valid && $stable(pulse_target))
    else $error("pulse request dropped before ack");
  a_pulse_clears: assert property (pulse_ack |-> ##[1:3] !pulse_valid)
    else $error("pulse request stays after ack");
  a_ack_cause: assert property (pulse_ack |-> $past(pulse_valid))
    else $error("ack without pulse request");
endmodule // sqno_props
`default_nettype wire

// ===== verification/station_query_and_network_options_bench.sv
`timescale 1ns/100ps
`default_nettype none
module station_query_and_network_options_bench;
  logic        clk, reset_n, wr, rd, net_long_frame, rx_valid_in, pulse_seen;
  logic [3:0]  addr, general_output_pins;
  logic [15:0] wdata, rv, rdata, d;
  logic [63:0] present;
  logic [4:0]  type_code;
  logic [5:0]  rx_station_in, station_address, owned_width, t;
  logic [8:0]  frame_length;
  int          n_errors, num_checks, n_pulse, gm, i, st[$];
  sqno_link_if link ();
  sqno_device i_sqno_device (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .general_output_pins(general_output_pins),
    .frame_length(frame_length), .station_address(station_address),
    .owned_width(owned_width), .link(link.dev));
  sqno_far_station #(.CYCLE_LEN(7'h20)) i_sqno_far_station (.clk(clk), .reset_n(reset_n),
    .present(present), .type_code(type_code), .net_long_frame(net_long_frame),
    .rx_valid_in(rx_valid_in), .rx_station_in(rx_station_in), .pulse_seen(pulse_seen),
    .link(link.far));
  sqno_props i_sqno_props (.clk(clk), .reset_n(reset_n), .query_valid(link.query_valid),
    .query_target(link.query_target), .query_answer(link.query_answer),
    .answer_type(link.answer_type), .pulse_valid(link.pulse_valid),
    .pulse_target(link.pulse_target), .pulse_ack(link.pulse_ack));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (pulse_seen === 1'b1) n_pulse++;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask
  task automatic poll(input int b);
    for (int k = 0; k < 40; k++) begin
      rreg(4'h0);
      if (rv[b] === 1'b0) break;
    end
  endtask
  task automatic wrap();
    for (int k = 0; k < 300; k++) begin
      cyc(1);
      if (link.cycle_wrap === 1'b1) break;
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
  initial begin
    {wr, rd, net_long_frame, rx_valid_in, addr, wdata, type_code, rx_station_in} = '0;
    present = ~(64'h1 << 40);
    reset_n = 1'b0;
    i = $urandom(32'he895);
    station_address = 6'($urandom_range(15));
    owned_width = 6'($urandom_range(63, 1));
    cyc(6);
    reset_n <= 1'b1;
    cyc(1);
    chk(general_output_pins, 16'h0);
    rreg(4'h3);
    chk(rv[5:0], 16'h3f);
    gm = 0;
    for (i = 0; i < 8; i++) begin
      d = 16'($urandom);
      if (i[0]) d[10:8] = 3'h0;
      wreg(4'h1, d);
      if (d[10:8] == 3'h0) gm = d[3:0];
      rreg(4'h1);
      chk(rv[3:0], gm);
      chk(general_output_pins, gm);
    end
    for (i = 0; i < 5; i++) begin
      t = 6'($urandom_range(39));
      type_code <= i[4:0];
      wreg(4'h0, {10'h001, t});
      poll(6);
      chk(rv, {3'h0, i[4:0], 2'b00, t});
    end
    wreg(4'h0, 16'h1f00);
    rreg(4'h0);
    chk(rv[12:6], 7'h10);
    wreg(4'h0, 16'h00e8);
    cyc(30);
    rreg(4'h0);
    chk(rv[7:6], 2'b11);
    chk(n_pulse, 0);
    wreg(4'h0, 16'h0087);
    poll(7);
    cyc(2);
    chk(rv[7:6], 2'b00);
    chk(n_pulse, 1);
    wreg(4'h2, 16'h0100);
    st = '{3, 9, int'(station_address)};
    wrap();
    foreach (st[k]) begin
      @(posedge clk);
      rx_valid_in <= 1'b1;
      rx_station_in <= 6'(st[k]);
    end
    @(posedge clk);
    rx_valid_in <= 1'b0;
    rreg(4'h5);
    chk(rv, 16'h0000);
    wrap();
    cyc(3);
    rreg(4'h5);
    gm = 0;
    foreach (st[k]) gm |= 1 << st[k];
    chk(rv, gm);
    wreg(4'h2, 16'h0000);
    wreg(4'h4, 16'h8000);
    wreg(4'h2, 16'h0080);
    cyc(4);
    chk(frame_length, 16'h100);
    rreg(4'h2);
    chk(rv[14], 1'b1);
    wreg(4'h2, 16'h0000);
    rreg(4'h2);
    chk(rv[14], 1'b1);
    reset_n <= 1'b0;
    cyc(6);
    reset_n <= 1'b1;
    cyc(1);
    chk(frame_length, 16'h080);
    chk(general_output_pins, 16'h0);
    rreg(4'h2);
    chk(rv[14], 1'b0);
    net_long_frame <= 1'b1;
    cyc(6);
    chk(frame_length, 16'h100);
    give_verdict();
  end
endmodule // station_query_and_network_options_bench
`default_nettype wire
